/* lock_pkg.sv */
package lock_pkg;
  localparam logic [7:0]  OPC_WREN       = 8'h06;
  localparam logic [7:0]  OPC_LOCK_ONE   = 8'h36;
  localparam logic [7:0]  OPC_UNLOCK_ONE = 8'h39;
  localparam logic [7:0]  OPC_READ_LOCK  = 8'h3d;
  localparam logic [7:0]  OPC_LOCK_ALL   = 8'h7e;
  localparam logic [7:0]  OPC_UNLOCK_ALL = 8'h98;
  localparam logic [7:0]  OPC_RST_EN     = 8'h66;
  localparam logic [7:0]  OPC_RST        = 8'h99;
  localparam logic [5:0]  BITS_OPC       = 6'h08;
  localparam logic [5:0]  BITS_ADDR      = 6'h20;
  localparam logic [5:0]  BITS_MAX       = 6'h3c;
  localparam int          LOCK_UNITS     = 64;
  localparam int          UNIT_MSB       = 21;
  localparam int          UNIT_LSB       = 16;
  localparam logic [63:0] LOCK_RESET     = 64'hffff_ffff_ffff_ffff;
  localparam int          CLK_MHZ        = 250;
  localparam int          RST_RECOV_US   = 30;
  localparam int          RECOV_CYC      = RST_RECOV_US * CLK_MHZ;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_RECOV = 3'b100
  } state_t;
endpackage

/* block_lock_and_soft_reset.sv */
`timescale 1ns/1ps
// Summary of operation
// - Individual lock bits decide write protection only when write_protect_select is one.
// - Otherwise protection comes from complement, granularity, top/bottom and block_protect_field.
// - Lock bits are volatile and all set to one after power-up or reset.
// - Opcode 39h plus 24-bit address, then select high, unlocks one unit.
// - Single unlock is accepted only while write_enable_latch is set.
// - Opcode 3Dh plus address returns lock byte MSB first on falling edges.
// - Readback byte LSB is one when locked, zero when unlocked.
// - Single lock commands work in SPI and quad_command_mode.
// - Opcode 7Eh alone sets every lock bit.
// - Opcode 98h alone clears every lock bit.
// - Global lock and unlock need write_enable_latch set.
// - Accepted reset aborts work, sets every lock bit and clears reset enable and latch.
// - Reset enable 66h and reset 99h work in both modes.
// - Reset happens only when 99h directly follows 66h; anything else cancels.
// - About 30us recovery follows reset, ignoring every command.
// - Opcode 36h plus address locks one unit when write_enable_latch is set.
module block_lock_and_soft_reset #(
  parameter int RECOV_CYC = lock_pkg::RECOV_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        cs_n_i,
  input  wire logic        sclk_i,
  input  wire logic [3:0]  dio_i,
  output logic      [3:0]  dio_o,
  output logic      [3:0]  dio_oe_o,
  input  wire logic        quad_command_mode_i,
  input  wire logic        write_protect_select_i,
  input  wire logic        complement_protect_i,
  input  wire logic        sector_granularity_i,
  input  wire logic        top_bottom_select_i,
  input  wire logic [2:0]  block_protect_field_i,
  input  wire logic [23:0] prot_addr_i,
  output logic             prot_o,
  output logic             write_enable_latch_o,
  output logic             soft_reset_o,
  output logic             reset_enable_o
);
  logic [2:0] cs_r, sclk_r;
  logic [3:0] dio_m_r, dio_s_r;
  lock_pkg::state_t state_r;
  logic [5:0]  cnt_r;
  logic [31:0] sh_r;
  logic [7:0]  rd_r;
  logic [63:0] lock_r;
  logic [13:0] recov_r;

  // Two-stage synchronisers plus one delay for edge detection
  always_ff @(posedge mclk_i) begin
    cs_r    <= {cs_r[1:0], cs_n_i};
    sclk_r  <= {sclk_r[1:0], sclk_i};
    dio_m_r <= dio_i;
    dio_s_r <= dio_m_r;
  end

  wire cs_fall   = cs_r[2] & ~cs_r[1];
  wire cs_rise   = ~cs_r[2] & cs_r[1];
  wire sck_rise  = ~sclk_r[2] & sclk_r[1] & ~cs_r[1];
  wire sck_fall  = sclk_r[2] & ~sclk_r[1] & ~cs_r[1];
  wire shifting  = state_r == lock_pkg::ST_SHIFT;
  wire [5:0] cnt_add = quad_command_mode_i ? 6'h04 : 6'h01;
  wire [5:0] cnt_sum = cnt_r + cnt_add;
  wire [31:0] sh_nxt = quad_command_mode_i ? {sh_r[27:0], dio_s_r} : {sh_r[30:0], dio_s_r[0]};
  wire [7:0] opc8    = sh_r[7:0];
  wire [7:0] opc32   = sh_r[31:24];
  wire [5:0] unit    = sh_r[lock_pkg::UNIT_MSB:lock_pkg::UNIT_LSB];
  wire end8  = shifting & cs_rise & (cnt_r == lock_pkg::BITS_OPC);
  wire end32 = shifting & cs_rise & (cnt_r == lock_pkg::BITS_ADDR);
  wire any_cmd   = shifting & cs_rise & (cnt_r != 6'h00);
  wire do_wren   = end8 & (opc8 == lock_pkg::OPC_WREN);
  wire do_lkall  = end8 & (opc8 == lock_pkg::OPC_LOCK_ALL) & write_enable_latch_o;
  wire do_ulall  = end8 & (opc8 == lock_pkg::OPC_UNLOCK_ALL) & write_enable_latch_o;
  wire do_lk1    = end32 & (opc32 == lock_pkg::OPC_LOCK_ONE) & write_enable_latch_o;
  wire do_ul1    = end32 & (opc32 == lock_pkg::OPC_UNLOCK_ONE) & write_enable_latch_o;
  wire do_rsten  = end8 & (opc8 == lock_pkg::OPC_RST_EN);
  wire do_rst    = end8 & (opc8 == lock_pkg::OPC_RST) & reset_enable_o;
  wire wel_clr   = do_lkall | do_ulall | do_lk1 | do_ul1;
  wire rd_load   = shifting & sck_rise & (cnt_sum == lock_pkg::BITS_ADDR)
                   & (sh_nxt[31:24] == lock_pkg::OPC_READ_LOCK);
  wire rd_phase  = shifting & (dio_oe_o != 4'h0);
  wire recov_done = recov_r == 14'(RECOV_CYC - 1);

  // Protection from the block_protect_field scheme
  wire [5:0] pa_unit = prot_addr_i[lock_pkg::UNIT_MSB:lock_pkg::UNIT_LSB];
  wire [9:0] pa_sec  = prot_addr_i[21:12];
  wire [5:0] u_idx   = top_bottom_select_i ? pa_unit : ~pa_unit;
  wire [9:0] s_idx   = top_bottom_select_i ? pa_sec : ~pa_sec;
  wire [2:0] bp_m1   = block_protect_field_i - 3'h1;
  wire [9:0] span    = 10'h001 << bp_m1;
  wire in_rng  = (block_protect_field_i != 3'h0)
                 & (sector_granularity_i ? (s_idx < span) : ({4'h0, u_idx} < span));
  wire bp_prot = complement_protect_i ^ in_rng;
  wire prot_nxt = write_protect_select_i ? lock_r[pa_unit] : bp_prot;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_r <= lock_pkg::ST_IDLE;
      recov_r <= 14'h0000;
    end else begin
      case (state_r)
        lock_pkg::ST_IDLE:  if (cs_fall) state_r <= lock_pkg::ST_SHIFT;
        lock_pkg::ST_SHIFT: if (do_rst) state_r <= lock_pkg::ST_RECOV;
                            else if (cs_rise) state_r <= lock_pkg::ST_IDLE;
        lock_pkg::ST_RECOV: begin
          recov_r <= recov_done ? 14'h0000 : recov_r + 14'h0001;
          if (recov_done) state_r <= lock_pkg::ST_IDLE;
        end
        default: state_r <= lock_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || cs_fall) begin
      cnt_r <= 6'h00;
      sh_r  <= 32'h0000_0000;
    end else if (shifting && sck_rise) begin
      cnt_r <= (cnt_r >= lock_pkg::BITS_MAX) ? cnt_r : cnt_sum;
      sh_r  <= sh_nxt;
    end
  end

  // Lock byte shifts out on falling edges, repeating while select stays low
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || cs_rise || !shifting) begin
      rd_r     <= 8'h00;
      dio_o    <= 4'h0;
      dio_oe_o <= 4'h0;
    end else if (rd_load) begin
      rd_r <= {7'h00, lock_r[sh_nxt[lock_pkg::UNIT_MSB:lock_pkg::UNIT_LSB]]};
    end else if ((sck_fall && cnt_r == lock_pkg::BITS_ADDR && rd_r[7:1] == 7'h00
                  && opc32 == lock_pkg::OPC_READ_LOCK)
                 || (sck_fall && rd_phase)) begin
      if (quad_command_mode_i) begin
        dio_o    <= rd_r[7:4];
        dio_oe_o <= 4'hf;
        rd_r     <= {rd_r[3:0], rd_r[7:4]};
      end else begin
        dio_o    <= {2'b00, rd_r[7], 1'b0};
        dio_oe_o <= 4'h2;
        rd_r     <= {rd_r[6:0], rd_r[7]};
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || do_rst || state_r == lock_pkg::ST_RECOV) begin
      lock_r               <= lock_pkg::LOCK_RESET;
      write_enable_latch_o <= 1'b0;
      reset_enable_o       <= 1'b0;
    end else begin
      if (do_lkall) lock_r <= lock_pkg::LOCK_RESET;
      else if (do_ulall) lock_r <= 64'h0000_0000_0000_0000;
      else if (do_lk1) lock_r[unit] <= 1'b1;
      else if (do_ul1) lock_r[unit] <= 1'b0;
      if (do_wren) write_enable_latch_o <= 1'b1;
      else if (wel_clr) write_enable_latch_o <= 1'b0;
      if (any_cmd) reset_enable_o <= do_rsten;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      prot_o       <= 1'b1;
      soft_reset_o <= 1'b0;
    end else begin
      prot_o       <= prot_nxt;
      soft_reset_o <= do_rst | (state_r == lock_pkg::ST_RECOV) & ~recov_done;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  lock_after_reset_a: assert property ($rose(rst_n_i) |-> lock_r == lock_pkg::LOCK_RESET)
    else $error("lock bits not all set after reset");
  unlock_one_a: assert property (do_ul1 && !do_rst |=> !lock_r[$past(unit)])
    else $error("unit not unlocked");
  wel_gate_a: assert property (!write_enable_latch_o && !do_rst |=> $stable(lock_r))
    else $error("locks changed without write enable");
  lock_all_a: assert property (do_lkall |=> lock_r == lock_pkg::LOCK_RESET)
    else $error("global lock failed");
  unlock_all_a: assert property (do_ulall |=> lock_r == 64'h0000_0000_0000_0000)
    else $error("global unlock failed");
  wel_clear_a: assert property (wel_clr |=> !write_enable_latch_o)
    else $error("write enable latch not cleared");
  rst_seq_a: assert property (do_rst |-> reset_enable_o ##1 state_r == lock_pkg::ST_RECOV)
    else $error("reset without reset enable");
  recov_hold_a: assert property (do_rst |=> (soft_reset_o && !write_enable_latch_o)[*8])
    else $error("recovery interval broken");
  wps_sel_a: assert property (write_protect_select_i |=> prot_o == $past(lock_r[pa_unit]))
    else $error("lock bit not used for protection");
  bp_sel_a: assert property (!write_protect_select_i |=> prot_o == $past(bp_prot))
    else $error("block protect scheme not used");
  read_lsb_a: assert property (rd_load |=> rd_r[7:1] == 7'h00)
    else $error("readback upper bits not zero");
  spi_out_a: assert property (rd_phase && !quad_command_mode_i |-> dio_oe_o == 4'h2)
    else $error("SPI readback on wrong line");
  // Checks on the command results and the recovery window
  lock_one_a: assert property (do_lk1 |=> lock_r[$past(unit)])
    else $error("unit not locked");
  rst_clear_a: assert property (do_rst |=> !write_enable_latch_o && !reset_enable_o)
    else $error("reset left volatile state set");
  ren_cancel_a: assert property (any_cmd && !do_rsten |=> !reset_enable_o)
    else $error("reset enable not cancelled");
  recov_ignore_a: assert property (state_r == lock_pkg::ST_RECOV |=> !write_enable_latch_o)
    else $error("command taken during recovery");
  quad_out_a: assert property (rd_phase && quad_command_mode_i |-> dio_oe_o == 4'hf)
    else $error("quad readback not on all lines");

  unlock_cv: cover property (do_ul1);
  readback_cv: cover property (rd_load ##[1:200] dio_oe_o != 4'h0);
  reset_cv: cover property (do_rst ##1 soft_reset_o);
  quad_lock_cv: cover property (do_lk1 && quad_command_mode_i);
  quad_reset_cv: cover property (do_rst && quad_command_mode_i);
endmodule // block_lock_and_soft_reset

/* spi_host_model.sv */
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic       mclk_i,
  input  wire logic       quad_i,
  input  wire logic [3:0] din_i,
  output logic            cs_n_o,
  output logic            sclk_o,
  output logic [3:0]      dout_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    dout_o = 4'h0;
  end
  // Clock idles low outside frames; bits read back just before each rise
  task automatic frame(input logic [31:0] b, input int n, input int rd, output logic [7:0] rb);
    int w;
    w = quad_i ? 4 : 1;
    rb = 8'h00;
    @(negedge mclk_i) cs_n_o = 1'b0;
    repeat (3) @(negedge mclk_i);
    for (int i = 0; i < n + rd; i += w) begin
      if (i < n) dout_o = quad_i ? b[31-i -: 4] : {3'h0, b[31-i]};
      repeat (6) @(negedge mclk_i);
      if (i >= n) rb = quad_i ? {rb[3:0], din_i} : {rb[6:0], din_i[1]};
      sclk_o = 1'b1;
      repeat (6) @(negedge mclk_i);
      sclk_o = 1'b0;
    end
    repeat (3) @(negedge mclk_i);
    cs_n_o = 1'b1;
    dout_o = ~dout_o;
    repeat (8) @(negedge mclk_i);
  endtask
endmodule // spi_host_model

/* block_lock_and_soft_reset_test.sv */
`timescale 1ns/1ps
module block_lock_and_soft_reset_test;
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        quad = 1'b0;
  logic        write_protect_select = 1'b1;
  logic        cmp = 1'b0;
  logic [23:0] paddr = 24'h0;
  logic [2:0]  bpf = 3'h0;
  logic        sec = 1'b0;
  logic        tbs = 1'b0;
  bit          ok;
  logic        cs_n, sclk, prot, write_enable_latch, srst, ren;
  logic [3:0]  hd, dd, doe, dw;
  logic [7:0]  rb;
  int          fail_count = 0;
  int          compares = 0;
  always #2 mclk_i = ~mclk_i;
  for (genvar k = 0; k < 4; k++) begin : g_wire
    assign dw[k] = doe[k] ? dd[k] : hd[k];
  end
  block_lock_and_soft_reset #(.RECOV_CYC(20)) block_lock_and_soft_reset_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sclk_i(sclk), .dio_i(dw),
    .dio_o(dd), .dio_oe_o(doe), .quad_command_mode_i(quad), .write_protect_select_i(write_protect_select),
    .complement_protect_i(cmp), .sector_granularity_i(sec), .top_bottom_select_i(tbs),
    .block_protect_field_i(bpf), .prot_addr_i(paddr), .prot_o(prot),
    .write_enable_latch_o(write_enable_latch), .soft_reset_o(srst), .reset_enable_o(ren));
  spi_host_model spi_host_model_inst (
    .mclk_i(mclk_i), .quad_i(quad), .din_i(dw), .cs_n_o(cs_n), .sclk_o(sclk), .dout_o(hd));
  task automatic finish_test();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    spi_host_model_inst.frame({op, 24'h0}, 8, 0, rb);
  endtask
  task automatic acmd(input logic [7:0] op, input logic [5:0] u);
    spi_host_model_inst.frame({op, 2'h0, u, 16'h0}, 32, 0, rb);
  endtask
  task automatic rdlock(input logic [5:0] u, input logic [7:0] exp);
    spi_host_model_inst.frame({8'h3d, 2'h0, u, 16'h0}, 32, 8, rb);
    chk(rb, exp);
  endtask
  task automatic pchk(input logic [5:0] u, input logic exp);
    @(negedge mclk_i) paddr = {2'h0, u, 16'h0};
    repeat (3) @(negedge mclk_i);
    chk({7'h0, prot}, {7'h0, exp});
  endtask
  task automatic t_unlock();
    rdlock(6'h05, 8'h01);
    acmd(8'h39, 6'h05);
    rdlock(6'h05, 8'h01);
    cmd(8'h06);
    chk({7'h0, write_enable_latch}, 8'h01);
    acmd(8'h39, 6'h05);
    chk({7'h0, write_enable_latch}, 8'h00);
    rdlock(6'h05, 8'h00);
    rdlock(6'h06, 8'h01);
  endtask
  task automatic t_prot();
    pchk(6'h05, 1'b0);
    pchk(6'h06, 1'b1);
    write_protect_select = 1'b0;
    pchk(6'h06, 1'b0);
    cmp = 1'b1;
    pchk(6'h05, 1'b1);
    cmp = 1'b0;
    bpf = 3'h2;
    tbs = 1'b1;
    pchk(6'h01, 1'b1);
    pchk(6'h05, 1'b0);
    tbs = 1'b0;
    pchk(6'h3f, 1'b1);
    tbs = 1'b1;
    sec = 1'b1;
    pchk(6'h00, 1'b1);
    pchk(6'h01, 1'b0);
    sec = 1'b0;
    bpf = 3'h0;
    tbs = 1'b0;
    write_protect_select = 1'b1;
    cmp = 1'b0;
  endtask
  task automatic t_global();
    cmd(8'h98);
    rdlock(6'h06, 8'h01);
    cmd(8'h06);
    cmd(8'h98);
    rdlock(6'h06, 8'h00);
    cmd(8'h06);
    acmd(8'h36, 6'h06);
    rdlock(6'h06, 8'h01);
    cmd(8'h06);
    cmd(8'h7e);
    rdlock(6'h05, 8'h01);
  endtask
  task automatic t_reset(output bit done);
    int n;
    cmd(8'h06);
    cmd(8'h98);
    cmd(8'h66);
    chk({7'h0, ren}, 8'h01);
    cmd(8'h06);
    cmd(8'h99);
    chk({6'h0, ren, srst}, 8'h00);
    cmd(8'h66);
    cmd(8'h99);
    chk({6'h0, srst, write_enable_latch}, 8'h02);
    n = 0;
    while (srst === 1'b1 && n < 40) begin
      @(negedge mclk_i);
      n++;
    end
    done = n < 40;
    chk({6'h0, done, n >= 8}, 8'h03);
    if (done) rdlock(6'h09, 8'h01);
  endtask
  task automatic t_quad(output bit done);
    quad = 1'b1;
    cmd(8'h06);
    acmd(8'h39, 6'h09);
    rdlock(6'h09, 8'h00);
    cmd(8'h06);
    acmd(8'h36, 6'h09);
    rdlock(6'h09, 8'h01);
    t_reset(done);
    quad = 1'b0;
  endtask
  initial begin
    repeat (12) @(negedge mclk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    t_unlock();
    t_prot();
    t_global();
    t_reset(ok);
    if (ok) t_quad(ok);
    finish_test();
  end
endmodule // block_lock_and_soft_reset_test
